// file: src/overflow_irq_status_bank.sv
// Overflow interrupt status bank: latched counter and FIFO overflow flags
// per group and per link, group interrupt enables and general status.
// Assumes one clock, synchronous one-cycle event pulses and an APB master.
//
// Functional notes
// R1 - Group enable bits 3:0 let a set group summary bit raise an interrupt.
// R2 - Unused upper bits of enable and cell-bus status registers read zero.
// R3 - Four group status registers; bit 4 latches receive FIFO overflow, 0 clears.
// R4 - Group bits 3:0 latch all, idle, unassigned, header-error counter overflow.
// R5 - System keeps line receive and transmit clocks running for these registers.
// R6 - Eight link cell-bus registers; bit 4 latches single-link receive FIFO overflow.
// R7 - Link cell-bus bits 3:0 latch all, idle, unassigned, header-error overflow.
// R8 - Line register bits 7:4 latch transmit all, idle, stuff, control overflow.
// R9 - Line register bits 3:0 latch receive all, idle, header-error, bad-control overflow.
// R10 - General status bits 7:4 hold a fixed read-only revision code.
// R11 - General bit 3 latches missing output cell-bus clock until written 0.
// R12 - General bit 2 latches missing input cell-bus clock until written 0.
// R13 - General bit 1 sets when any transmit cell-bus FIFO overflows.
// R14 - General bit 0 latches exhausted transmit cell RAM until written 0.
// R15 - Group summary bit sets when any group counter or its FIFO overflows.
// R16 - Service bit 7 reads 1 while any enabled group source requests service.
// R17 - A set event in the clearing cycle wins over the clear.
// R18 - Writing 1 leaves a latched bit unchanged; only 0 clears. Interrupt status bits instead clear on a written 1.
`timescale 1ns/1ns
`default_nettype none

module overflow_irq_status_bank #(
  parameter int N_LINKS  = 8,
  parameter int N_GROUPS = 4
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [N_GROUPS-1:0]   group_fifo_ovf_i,
  input  wire logic [4*N_GROUPS-1:0] group_cnt_ovf_i,
  input  wire logic [N_LINKS-1:0]    link_fifo_ovf_i,
  input  wire logic [N_LINKS-1:0]    link_single_mode_i,
  input  wire logic [4*N_LINKS-1:0]  link_cnt_ovf_i,
  input  wire logic [8*N_LINKS-1:0]  line_cnt_ovf_i,
  input  wire logic                  out_clk_missing_i,
  input  wire logic                  in_clk_missing_i,
  input  wire logic                  tx_fifo_ovf_i,
  input  wire logic                  tx_ram_full_i,
  output logic                       group_service_o,
  output logic                       irq_o
);

  if (N_LINKS < 1 || N_LINKS > 8 || N_GROUPS < 1 || N_GROUPS > 4) begin : g_bad_params
    $error("overflow_irq_status_bank: unsupported link or group count");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [9:0] idx;
  logic       word_ok;
  logic       setup;
  logic       wr;
  logic [7:0] wbyte;

  assign idx     = paddr_i[11:2];
  assign word_ok = paddr_i[1:0] == 2'b00;
  assign setup   = psel_i && !penable_i;
  assign wr      = psel_i && penable_i && pwrite_i;
  assign wbyte   = pwdata_i[7:0];
  // Zero wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;

  logic hit_enable;
  logic hit_general;
  logic hit_summary;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic hit_service;

  assign hit_enable   = word_ok && idx == ovf_irq_pkg::IDX_GROUP_ENABLE;
  assign hit_general  = word_ok && idx == ovf_irq_pkg::IDX_GENERAL;
  assign hit_summary  = word_ok && idx == ovf_irq_pkg::IDX_GROUP_SUMMARY;
  assign hit_irq_st   = word_ok && idx == ovf_irq_pkg::IDX_IRQ_STATUS;
  assign hit_irq_mask = word_ok && idx == ovf_irq_pkg::IDX_IRQ_MASK;
  assign hit_service  = word_ok && idx == ovf_irq_pkg::IDX_SERVICE;

  //////////////////////////////////////////////////////////////////////////////
  // Group enable and group status

  logic [3:0]          group_enable;
  logic [4:0]          group_st [N_GROUPS];
  logic [N_GROUPS-1:0] hit_group;
  logic [N_GROUPS-1:0] summary;
  logic [7:0]          rd_group [N_GROUPS];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      group_enable <= ovf_irq_pkg::RESET_FLAG;
    end else if (wr && hit_enable) begin
      group_enable <= wbyte[3:0];
    end
  end

  for (genvar g = 0; g < N_GROUPS; g++) begin : g_group
    logic [4:0] set;
    logic [4:0] next_st;
    assign hit_group[g] = word_ok && idx == ovf_irq_pkg::IDX_GROUP_STATUS + 10'(g);
    assign set = {group_fifo_ovf_i[g], group_cnt_ovf_i[4*g +: 4]}; // [R3] [R4]
    // And with the written byte so 1 keeps and 0 clears; set or-ed last
    assign next_st = (hit_group[g] && wr) ? ((group_st[g] & wbyte[4:0]) | set) // [R17] [R18]
                                          : (group_st[g] | set);
    assign summary[g]  = |group_st[g]; // [R15]
    assign rd_group[g] = hit_group[g] ? {3'b000, group_st[g]} : 8'h00; // [R2]
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        group_st[g] <= ovf_irq_pkg::RESET_CB;
      end else begin
        group_st[g] <= next_st;
      end
    end
  end

  logic [3:0] summary_w;
  assign summary_w = 4'(summary);
  // Service clears when the underlying status bits or the matching group enable bits are cleared
  assign group_service_o = |(summary_w & group_enable); // [R1] [R16]

  //////////////////////////////////////////////////////////////////////////////
  // Per-link cell-bus and line status

  logic [4:0]         link_cb [N_LINKS];
  logic [7:0]         line_st [N_LINKS];
  logic [N_LINKS-1:0] hit_cb;
  logic [N_LINKS-1:0] hit_line;
  logic [7:0]         rd_link [N_LINKS];

  for (genvar l = 0; l < N_LINKS; l++) begin : g_link
    logic [4:0] cb_set;
    logic [7:0] line_set;
    logic [4:0] next_cb;
    logic [7:0] next_line;
    assign hit_cb[l]   = word_ok && idx == ovf_irq_pkg::IDX_LINK_CELLBUS + 10'(l);
    assign hit_line[l] = word_ok && idx == ovf_irq_pkg::IDX_LINK_LINE + 10'(l);
    // FIFO overflow counts only while the link runs on its own
    assign cb_set   = {link_fifo_ovf_i[l] && link_single_mode_i[l],
                       link_cnt_ovf_i[4*l +: 4]}; // [R6] [R7]
    assign line_set = line_cnt_ovf_i[8*l +: 8]; // [R8] [R9]
    assign next_cb   = (hit_cb[l] && wr) ? ((link_cb[l] & wbyte[4:0]) | cb_set) // [R17] [R18]
                                         : (link_cb[l] | cb_set);
    assign next_line = (hit_line[l] && wr) ? ((line_st[l] & wbyte) | line_set) // [R17] [R18]
                                           : (line_st[l] | line_set);
    assign rd_link[l] = (hit_cb[l] ? {3'b000, link_cb[l]} : 8'h00) // [R2]
                      | (hit_line[l] ? line_st[l] : 8'h00);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        link_cb[l] <= ovf_irq_pkg::RESET_CB;
        line_st[l] <= ovf_irq_pkg::RESET_BYTE;
      end else begin
        link_cb[l] <= next_cb;
        line_st[l] <= next_line;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // General status

  logic [3:0] gen_flags;
  logic [3:0] gen_set;
  logic [3:0] next_gen;

  assign gen_set = {out_clk_missing_i, in_clk_missing_i,
                    tx_fifo_ovf_i, tx_ram_full_i}; // [R11] [R12] [R13] [R14]
  assign next_gen = (hit_general && wr) ? ((gen_flags & wbyte[3:0]) | gen_set) // [R17] [R18]
                                        : (gen_flags | gen_set);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gen_flags <= ovf_irq_pkg::RESET_FLAG;
    end else begin
      gen_flags <= next_gen;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask: bits 3:0 enabled groups, bits 7:4 general flags

  logic [7:0] irq_st;
  logic [7:0] irq_mask;
  logic [7:0] irq_set;
  logic [7:0] next_irq_st;

  assign irq_set = {gen_set, summary_w & group_enable}; // [R1]
  // Write one to clear; a fresh event in the same cycle wins
  assign next_irq_st = (hit_irq_st && wr) ? ((irq_st & ~wbyte) | irq_set) // [R17]
                                          : (irq_st | irq_set);
  assign irq_o = |(irq_st & irq_mask);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_st   <= ovf_irq_pkg::RESET_BYTE;
      irq_mask <= ovf_irq_pkg::RESET_BYTE;
    end else begin
      irq_st <= next_irq_st;
      if (wr && hit_irq_mask) begin
        irq_mask <= wbyte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path, captured in the setup cycle

  logic [7:0] rd_tables;
  logic [7:0] rd_byte;
  logic       hit_any;

  always_comb begin
    rd_tables = 8'h00;
    for (int i = 0; i < N_GROUPS; i++) begin
      rd_tables = rd_tables | rd_group[i];
    end
    for (int i = 0; i < N_LINKS; i++) begin
      rd_tables = rd_tables | rd_link[i];
    end
  end

  assign rd_byte = rd_tables
                 | (hit_enable  ? {4'h0, group_enable} : 8'h00) // [R2]
                 | (hit_general ? {ovf_irq_pkg::REVISION, gen_flags} : 8'h00) // [R10]
                 | (hit_summary ? {4'h0, summary_w} : 8'h00)
                 | (hit_irq_st  ? irq_st : 8'h00)
                 | (hit_irq_mask ? irq_mask : 8'h00)
                 | (hit_service ? {group_service_o, 7'h00} : 8'h00); // [R16]
  assign hit_any = hit_enable || hit_general || hit_summary || hit_irq_st
                || hit_irq_mask || hit_service || (|hit_group) || (|hit_cb)
                || (|hit_line);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_o <= !hit_any;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb_main @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic gen_wr;
  logic g0_wr;
  logic cb0_wr;
  logic line0_wr;
  assign gen_wr   = wr && hit_general;
  assign g0_wr    = wr && hit_group[0];
  assign cb0_wr   = wr && hit_cb[0];
  assign line0_wr = wr && hit_line[0];

  a_enable_upper_zero: assert property ( // [R2]
    setup && !pwrite_i && hit_enable |=> prdata_o[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  a_status_upper_zero: assert property ( // [R2]
    setup && !pwrite_i && ((|hit_group) || (|hit_cb)) |=> prdata_o[7:5] == 3'b000)
    else $error("status upper bits not zero");
  a_group_fifo_latch: assert property ( // [R3]
    group_fifo_ovf_i[0] |=> group_st[0][4] [*2] or (g0_wr && !pwdata_i[4]))
    else $error("group fifo overflow not latched");
  a_group_fifo_clear: assert property ( // [R3]
    g0_wr && !pwdata_i[4] && !group_fifo_ovf_i[0] |=> !group_st[0][4])
    else $error("group fifo flag not cleared by zero write");
  a_group_cnt_order: assert property ( // [R4]
    group_cnt_ovf_i[3] |=> group_st[0][3] && summary[0])
    else $error("group all-cells overflow not in bit 3");
  a_link_fifo_mode: assert property ( // [R6]
    link_fifo_ovf_i[0] && !link_single_mode_i[0] && !link_cb[0][4] && !cb0_wr |=> !link_cb[0][4])
    else $error("link fifo latched outside single-link mode");
  a_link_fifo_latch: assert property ( // [R6]
    link_fifo_ovf_i[1] && link_single_mode_i[1] |=> link_cb[1][4])
    else $error("single-link fifo overflow not latched");
  a_link_cnt_order: assert property ( // [R7]
    link_cnt_ovf_i[0] |=> link_cb[0][0])
    else $error("link header-error overflow not in bit 0");
  a_link_cb_clear: assert property ( // [R7]
    cb0_wr && pwdata_i[4:0] == 5'h00 && link_cnt_ovf_i[3:0] == 4'h0 && !link_fifo_ovf_i[0]
    |=> link_cb[0] == 5'h00)
    else $error("cell-bus flags not cleared by zero write");
  a_line_tx_order: assert property ( // [R8]
    line_cnt_ovf_i[7] |=> line_st[0][7])
    else $error("transmit all-cells overflow not in bit 7");
  a_line_rx_order: assert property ( // [R9]
    line_cnt_ovf_i[1] |=> line_st[0][1])
    else $error("receive header-error overflow not in bit 1");
  a_line_clear: assert property ( // [R8] [R9]
    line0_wr && pwdata_i[7:0] == 8'h00 && line_cnt_ovf_i[7:0] == 8'h00 |=> line_st[0] == 8'h00)
    else $error("line flags not cleared by zero write");
  a_revision_fixed: assert property ( // [R10]
    setup && !pwrite_i && hit_general |=> prdata_o[7:4] == ovf_irq_pkg::REVISION)
    else $error("revision field changed");
  a_out_clk_hold: assert property ( // [R11]
    gen_flags[3] && !(gen_wr && !pwdata_i[3]) |=> gen_flags[3])
    else $error("output clock flag dropped without clear");
  a_in_clk_hold: assert property ( // [R12]
    gen_flags[2] && !(gen_wr && !pwdata_i[2]) |=> gen_flags[2])
    else $error("input clock flag dropped without clear");
  a_tx_fifo_set: assert property ( // [R13]
    tx_fifo_ovf_i |=> gen_flags[1])
    else $error("transmit fifo overflow not flagged");
  a_tx_ram_clear: assert property ( // [R14]
    gen_wr && !pwdata_i[0] && !tx_ram_full_i |=> !gen_flags[0])
    else $error("ram-full flag not cleared by zero write");
  a_summary_any: assert property ( // [R15]
    group_cnt_ovf_i[1] |=> summary[0])
    else $error("group summary not set by counter overflow");
  a_set_beats_clear: assert property ( // [R17]
    g0_wr && pwdata_i[7:0] == 8'h00 && group_cnt_ovf_i[0] |=> group_st[0][0])
    else $error("set lost against clear");
  a_one_keeps: assert property ( // [R18]
    g0_wr && pwdata_i[2] |=> group_st[0][2] == $past(group_st[0][2]) || $past(group_cnt_ovf_i[2]))
    else $error("writing one changed a latched bit");
  a_gen_one_keeps: assert property ( // [R18]
    gen_wr && pwdata_i[3] |=> gen_flags[3] == $past(gen_flags[3]) || $past(out_clk_missing_i))
    else $error("writing one changed a general flag");
  a_group_irq_path: assert property ( // [R1]
    summary[0] && group_enable[0] && irq_mask[0] && !(wr && hit_irq_mask) |=> irq_o)
    else $error("enabled group did not interrupt");
  a_service_level: assert property ( // [R16]
    summary[0] && group_enable[0] |-> group_service_o)
    else $error("service request missing for enabled group");
  a_service_bit: assert property ( // [R16]
    setup && !pwrite_i && hit_service && group_service_o |=> prdata_o[7])
    else $error("service bit not read as one");

  c_group_irq: cover property (summary[0] && group_enable[0] ##1 irq_o);
  c_clear_flag: cover property (gen_flags[0] ##1 gen_wr && !pwdata_i[0] ##1 !gen_flags[0]);
  c_unmapped: cover property (psel_i && penable_i && pslverr_o);
  c_set_and_clear: cover property (gen_wr && !pwdata_i[0] && tx_ram_full_i);
  c_link_single_fifo: cover property (link_fifo_ovf_i[1] && link_single_mode_i[1]);

endmodule // overflow_irq_status_bank

`default_nettype wire

// file: src/ovf_irq_pkg.sv
// Constants for the overflow interrupt status bank.
// Assumes an APB master with 32-bit data; register indices are word numbers.
package ovf_irq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_GROUP_ENABLE  = 10'h204;
  localparam logic [9:0] IDX_GENERAL       = 10'h206;
  localparam logic [9:0] IDX_LINK_CELLBUS  = 10'h208;
  localparam logic [9:0] IDX_GROUP_STATUS  = 10'h210;
  localparam logic [9:0] IDX_LINK_LINE     = 10'h22A;
  localparam logic [9:0] IDX_GROUP_SUMMARY = 10'h235;
  localparam logic [9:0] IDX_IRQ_STATUS    = 10'h240;
  localparam logic [9:0] IDX_IRQ_MASK      = 10'h241;
  localparam logic [9:0] IDX_SERVICE       = 10'h242;

  // Field positions
  localparam int FIFO_BIT    = 4;
  localparam int REV_LSB     = 4;
  localparam int OUT_CLK_BIT = 3;
  localparam int IN_CLK_BIT  = 2;
  localparam int TX_FIFO_BIT = 1;
  localparam int RAM_BIT     = 0;
  localparam int SERVICE_BIT = 7;

  // Values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] RESET_CB   = 5'h00;
  localparam logic [3:0] RESET_FLAG = 4'h0;

  // Arbitrary neutral revision code
  localparam logic [3:0] REVISION = 4'h5;

endpackage : ovf_irq_pkg

// file: test/overflow_irq_status_bank_tb_top.sv
// Self-checking bench for the overflow interrupt status bank.
// Assumes the design package and one 100 MHz clock; the APB master lives here.
`timescale 1ns/1ns
`default_nettype none

module overflow_irq_status_bank_tb_top;
  localparam logic [9:0] ENA = ovf_irq_pkg::IDX_GROUP_ENABLE;
  localparam logic [9:0] GEN = ovf_irq_pkg::IDX_GENERAL;
  localparam logic [9:0] GST = ovf_irq_pkg::IDX_GROUP_STATUS;
  localparam logic [9:0] IRQ = ovf_irq_pkg::IDX_IRQ_STATUS;
  localparam logic [9:0] CBS = ovf_irq_pkg::IDX_LINK_CELLBUS;
  localparam logic [9:0] LNS = ovf_irq_pkg::IDX_LINK_LINE;
  localparam logic [7:0] REV0 = {ovf_irq_pkg::REVISION, 4'h0};
  logic        clk_i     = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [3:0]  gfifo     = 4'h0;
  logic [15:0] gcnt      = 16'h0000;
  logic [7:0]  lfifo     = 8'h00;
  logic [7:0]  lsingle   = 8'h00;
  logic [31:0] lcnt      = 32'h0000_0000;
  logic [63:0] linecnt   = 64'h0000_0000_0000_0000;
  logic [3:0]  gen_ev    = 4'h0;
  logic        group_service_o;
  logic        irq_o;
  int          mismatches      = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h0000_99c4;
  logic [7:0]  rd;
  logic        er;
  logic [3:0]  sum;
  logic [3:0]  gflags;

  // Line receive and transmit clocks run with this one clock throughout
  always #5 clk_i = ~clk_i;

  overflow_irq_status_bank overflow_irq_status_bank_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .group_fifo_ovf_i(gfifo),
    .group_cnt_ovf_i(gcnt), .link_fifo_ovf_i(lfifo), .link_single_mode_i(lsingle),
    .link_cnt_ovf_i(lcnt), .line_cnt_ovf_i(linecnt), .out_clk_missing_i(gen_ev[3]),
    .in_clk_missing_i(gen_ev[2]), .tx_fifo_ovf_i(gen_ev[1]), .tx_ram_full_i(gen_ev[0]),
    .group_service_o(group_service_o), .irq_o(irq_o));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Cell-bus byte: FIFO overflow only counts in single-link mode
  function automatic logic [7:0] exp_cb(input logic [5:0] s);
    return {3'b000, s[4] & s[5], s[3:0]};
  endfunction

  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Hit raises the RAM event in the access cycle, so it meets the write edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     input logic hit);
    int n;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= {idx, 2'b00};
    pwdata_i <= {24'h00_0000, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    gen_ev[0] <= hit;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      mismatches++;
      final_report();
    end
    rd = prdata_o[7:0];
    er = pslverr_o;
    chk("rdata_upper", {8'h00, prdata_o[31:8]}, 32'h0000_0000);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    gen_ev[0] <= 1'b0;
    @(negedge clk_i);
  endtask

  // Events are high for exactly the next edge
  task automatic drop_events;
    @(posedge clk_i);
    gfifo   <= '0;
    gcnt    <= '0;
    lfifo   <= '0;
    lcnt    <= '0;
    linecnt <= '0;
    gen_ev  <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    apb(0, ENA, 0, 0);
    chk("enable_rst", rd, 8'h00);
    apb(1, GEN, 8'h00, 0);
    apb(0, GEN, 0, 0);
    chk("revision", rd, REV0);
    apb(1, ENA, 8'hFF, 0);
    apb(0, ENA, 0, 0);
    chk("enable", rd, 8'h0F);
    sum = 4'h0;
    for (int g = 0; g < 4; g++) begin
      seed = lfsr(seed);
      if (g == 0) begin
        seed[4:0] = 5'h1F;
      end
      @(posedge clk_i);
      gcnt[4*g +: 4] <= seed[3:0];
      gfifo[g]       <= seed[4];
      drop_events();
      sum[g] = |seed[4:0];
      apb(0, GST + 10'(g), 0, 0);
      chk("group_status", rd, {3'b000, seed[4:0]});
    end
    apb(0, ovf_irq_pkg::IDX_GROUP_SUMMARY, 0, 0);
    chk("summary", rd, {4'h0, sum});
    chk("service", group_service_o, |sum);
    apb(0, ovf_irq_pkg::IDX_SERVICE, 0, 0);
    chk("service_reg", rd, {|sum, 7'h00});
    apb(1, ENA, 8'h00, 0);
    chk("service_off", group_service_o, 1'b0);
    apb(1, ENA, 8'h0F, 0);
    apb(1, ovf_irq_pkg::IDX_IRQ_MASK, 8'h0F, 0);
    chk("irq_group", irq_o, 1'b1);
    apb(1, GST, 8'hFF, 0);
    apb(0, GST, 0, 0);
    chk("write_one", rd, 8'h1F);
    for (int g = 0; g < 4; g++) begin
      apb(1, GST + 10'(g), 8'h00, 0);
    end
    apb(0, GST, 0, 0);
    chk("group_clr", rd, 8'h00);
    chk("service_clr", group_service_o, 1'b0);
    apb(1, IRQ, 8'h0F, 0);
    chk("irq_clr", irq_o, 1'b0);
    for (int l = 0; l < 8; l++) begin
      seed = lfsr(seed);
      if (l < 2) begin
        seed[5:4] = {l[0], 1'b1};
      end
      @(posedge clk_i);
      lsingle[l]         <= seed[5];
      lfifo[l]           <= seed[4];
      lcnt[4*l +: 4]     <= seed[3:0];
      linecnt[8*l +: 8]  <= seed[15:8];
      drop_events();
      apb(0, CBS + 10'(l), 0, 0);
      chk("link_cb", rd, exp_cb(seed[5:0]));
      apb(0, LNS + 10'(l), 0, 0);
      chk("link_line", rd, seed[15:8]);
    end
    apb(1, CBS, 8'h00, 0);
    apb(0, CBS, 0, 0);
    chk("link_cb_clr", rd, 8'h00);
    apb(1, LNS, 8'h00, 0);
    apb(0, LNS, 0, 0);
    chk("link_line_clr", rd, 8'h00);
    gflags = 4'h0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      gen_ev <= 4'b0001 << k;
      drop_events();
      gflags[k] = 1'b1;
      apb(0, GEN, 0, 0);
      chk("general", rd, {REV0[7:4], gflags});
    end
    chk("irq_masked", irq_o, 1'b0);
    apb(1, ovf_irq_pkg::IDX_IRQ_MASK, 8'hF0, 0);
    chk("irq_raise", irq_o, 1'b1);
    apb(1, GEN, 8'h0F, 0);
    apb(0, GEN, 0, 0);
    chk("gen_keep", rd, REV0 | 8'h0F);
    apb(1, GEN, 8'h00, 1);
    apb(0, GEN, 0, 0);
    chk("set_wins", rd, REV0 | 8'h01);
    apb(1, GEN, 8'h00, 0);
    apb(0, GEN, 0, 0);
    chk("gen_clr", rd, REV0);
    apb(1, IRQ, 8'hF0, 0);
    chk("irq_clear", irq_o, 1'b0);
    apb(0, 10'h300, 0, 0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 8'h00);
    final_report();
  end
endmodule // overflow_irq_status_bank_tb_top

`default_nettype wire
